// *** include/ldd_pkg.sv ***
// Constants, enumerations and register map of the LED driver diagnostics block
// What this block does
// - Select codes 00h-05h pick internal channels
// - Codes 10h-1Bh pick outputs; 1Ch-1Fh reserved
// - Auto-scan maximum stores highest output voltage
// - Maximum valid only after one PWM period
// - Only report faults; act on undervoltage only
// - Masking keeps detection, blocks reporting only
// - Disabled channel diagnostics report no faults
// - Reference mask blocks global flag, pin
// - Open mask blocks out, global flags, pin
// - Short mask blocks out, global flags, pin
// - Thermal mask blocks global flag, pin
// - CRC mask blocks global flag, pin
// - Undervoltage forces reset; recovery sets flags
// - Low supply pulses pin, sets flag
// - Fault clear resets flags, self-returns zero
// - Idle converter starts a supply conversion when no select is pending
// - Open, single-short diagnosis need adequate supply
// - Low-supply threshold spans 5 V to 20 V
// - Reference open and short comparators flag faults
// - Reference fault holds pin low continuously
// - Select write starts conversion, clears done
// - Result read clears done after completion
package ldd_pkg;

	localparam int unsigned NCH = 12;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MASK   = 8'h04;
	localparam logic [7:0] ADDR_DIAG   = 8'h08;
	localparam logic [7:0] ADDR_TH     = 8'h0c;
	localparam logic [7:0] ADDR_SEL    = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h14;
	localparam logic [7:0] ADDR_SUPPLY = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_OPEN   = 8'h20;
	localparam logic [7:0] ADDR_SHORT  = 8'h24;
	localparam logic [7:0] ADDR_SS     = 8'h28;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int unsigned CTRL_CLR  = 0;
	localparam int unsigned CTRL_SCAN = 1;
	localparam int unsigned CTRL_INIT = 2;
	localparam int unsigned MK_REF    = 0;
	localparam int unsigned MK_OPEN   = 1;
	localparam int unsigned MK_SHORT  = 2;
	localparam int unsigned MK_TSD    = 3;
	localparam int unsigned MK_CRC    = 4;
	localparam int unsigned MK_W      = 5;
	localparam int unsigned SEL_W     = 5;
	localparam logic [11:0] DIAG_EN_RST = 12'hfff;
	// Supply codes for 5 V and 20 V at 0.0804 V per step
	localparam logic [7:0]  TH_MIN = 8'h3d;
	localparam logic [7:0]  TH_MAX = 8'hf8;

	// ****************************************************************
	// Converter channel codes
	// ****************************************************************
	localparam logic [4:0] CH_SUPPLY = 5'h01;
	localparam logic [4:0] CH_MAX    = 5'h05;
	localparam logic [4:0] CH_RSV_LO = 5'h06;
	localparam logic [4:0] CH_RSV_HI = 5'h0f;
	localparam logic [4:0] CH_OUT0   = 5'h10;
	localparam logic [4:0] CH_OUT11  = 5'h1b;

	// ****************************************************************
	// Timing and bus answers
	// ****************************************************************
	localparam int unsigned PULSE_US = 50;
	localparam int unsigned CLK_MHZ  = 40;
	localparam logic [11:0] PULSE_CYC = 12'(PULSE_US * CLK_MHZ);
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Synchroniser vector layout
	localparam int unsigned SY_SUP_UV = 0;
	localparam int unsigned SY_REG_UV = 1;
	localparam int unsigned SY_REF_I  = 2;
	localparam int unsigned SY_REF_V  = 3;
	localparam int unsigned SY_TSD    = 4;
	localparam int unsigned SY_OPEN   = 5;
	localparam int unsigned SY_SHORT  = SY_OPEN + NCH;
	localparam int unsigned SY_SS     = SY_SHORT + NCH;
	localparam int unsigned SY_W      = SY_SS + NCH;

	typedef enum logic [1:0] {PWR_POR, PWR_INIT, PWR_NORMAL} ldd_pwr_e;
	typedef enum logic [1:0] {ADC_IDLE, ADC_SUP, ADC_MAN, ADC_SCAN} ldd_adc_e;

endpackage : ldd_pkg

// *** core/ldd_diag.sv ***
// Diagnostics, fault reporting and converter sequencing with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module ldd_diag #(
	parameter int unsigned AW = 8
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [AW-1:0]              s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [AW-1:0]              s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       supply_uv,
	input  wire logic                       regulator_uv,
	input  wire logic                       ref_current_low,
	input  wire logic                       ref_voltage_low,
	input  wire logic                       tsd_det,
	input  wire logic [ldd_pkg::NCH-1:0]    open_det,
	input  wire logic [ldd_pkg::NCH-1:0]    short_det,
	input  wire logic [ldd_pkg::NCH-1:0]    ss_det,
	input  wire logic                       crc_err,
	input  wire logic                       pwm_period_end,
	input  wire logic                       adc_done,
	input  wire logic [7:0]                 adc_data,
	output logic                            adc_start,
	output logic [4:0]                      adc_mux,
	output logic                            err_n
);
	import ldd_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [SY_W-1:0]  sy1;
		logic [SY_W-1:0]  sy2;
		ldd_pwr_e         pwr;
		ldd_adc_e         adc;
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             rd_result;
		logic             aw_have;
		logic             w_have;
		logic [7:0]       awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             fault_clear;
		logic             auto_scan;
		logic [MK_W-1:0]  mask;
		logic [NCH-1:0]   diag_en;
		logic [7:0]       low_th;
		logic [SEL_W-1:0] sel;
		logic             manual_pend;
		logic             adc_start;
		logic [4:0]       adc_mux;
		logic [3:0]       scan_idx;
		logic [7:0]       max_v;
		logic             period_seen;
		logic [7:0]       result;
		logic [7:0]       supply;
		logic             supply_ok;
		logic             done;
		logic             err;
		logic             out;
		logic             por;
		logic             low_sup;
		logic             ref_f;
		logic             tsd;
		logic             crc;
		logic [NCH-1:0]   open_f;
		logic [NCH-1:0]   short_f;
		logic [NCH-1:0]   ss_f;
		logic [11:0]      pulse_cnt;
		logic             err_n;
	} ldd_state_s;

	ldd_state_s       s;
	ldd_state_s       next_s;
	logic [SY_W-1:0]  pins_raw;
	logic             wr_fire;
	logic [31:0]      wr_word;
	logic [31:0]      wmask;
	logic             uv;
	logic             active;
	logic [NCH-1:0]   open_set;
	logic [NCH-1:0]   short_set;
	logic [NCH-1:0]   ss_set;
	logic             ref_set;
	logic             rep_open;
	logic             rep_short;
	logic             const_low;
	logic             trig;
	logic             lsup_evt;
	logic [7:0]       mx;

	assign pins_raw = {ss_det, short_det, open_det, tsd_det, ref_voltage_low,
		ref_current_low, regulator_uv, supply_uv};

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a <= ADDR_SS) && (a[1:0] == 2'h0);
	endfunction : is_mapped

	function automatic logic [31:0] reg_word(input logic [7:0] a,
		input ldd_state_s st);
		reg_word = 32'h0;
		if (a == ADDR_CTRL) begin
			reg_word = {30'h0, st.auto_scan, st.fault_clear};
		end else if (a == ADDR_MASK) begin
			reg_word = {27'h0, st.mask};
		end else if (a == ADDR_DIAG) begin
			reg_word = {20'h0, st.diag_en};
		end else if (a == ADDR_TH) begin
			reg_word = {24'h0, st.low_th};
		end else if (a == ADDR_SEL) begin
			reg_word = {27'h0, st.sel};
		end else if (a == ADDR_RESULT) begin
			reg_word = {24'h0, st.result};
		end else if (a == ADDR_SUPPLY) begin
			reg_word = {24'h0, st.supply};
		end else if (a == ADDR_STATUS) begin
			reg_word = {21'h0, st.supply_ok, st.pwr, st.crc, st.tsd, st.ref_f,
				st.low_sup, st.por, st.out, st.err, st.done};
		end else if (a == ADDR_OPEN) begin
			reg_word = {20'h0, st.open_f};
		end else if (a == ADDR_SHORT) begin
			reg_word = {20'h0, st.short_f};
		end else if (a == ADDR_SS) begin
			reg_word = {20'h0, st.ss_f};
		end
	endfunction : reg_word

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		next_s.sy1 = pins_raw;
		next_s.sy2 = s.sy1;
		next_s.adc_start = 1'b0;
		wr_fire = 1'b0;
		lsup_evt = 1'b0;
		mx = 8'h0;
		wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}},
			{8{s.wstrb[0]}}};
		wr_word = (reg_word(s.awaddr, s) & ~wmask) | (s.wdata & wmask);
		uv = s.sy2[SY_SUP_UV] | s.sy2[SY_REG_UV];
		active = (s.pwr != PWR_POR) && !uv;
		open_set = s.sy2[SY_OPEN +: NCH] & s.diag_en & {NCH{s.supply_ok}};
		short_set = s.sy2[SY_SHORT +: NCH] & s.diag_en;
		ss_set = s.sy2[SY_SS +: NCH] & s.diag_en & {NCH{s.supply_ok}};
		ref_set = s.sy2[SY_REF_I] | s.sy2[SY_REF_V];
		rep_open = active && (|open_set) && !s.mask[MK_OPEN];
		rep_short = active && (|(short_set | ss_set)) && !s.mask[MK_SHORT];
		const_low = active && ((ref_set && !s.mask[MK_REF]) ||
			(s.sy2[SY_TSD] && !s.mask[MK_TSD]));

		// Read channel; done is cleared only once the data beat is taken
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.rd_result = 1'b0;
			if (s.rd_result) begin
				next_s.done = 1'b0;
			end
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = reg_word(s_axi_araddr[7:0], s);
			next_s.rresp = is_mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
			next_s.rd_result = (s_axi_araddr[7:0] == ADDR_RESULT);
		end
		next_s.arready = !next_s.rvalid;

		// Write channels are taken independently, applied when both are held
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_have && s.w_have && !s.bvalid) begin
			wr_fire = 1'b1;
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = is_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		next_s.awready = !next_s.aw_have && !next_s.bvalid;
		next_s.wready = !next_s.w_have && !next_s.bvalid;

		// Clear acts first so that a fault in the same cycle survives
		if (s.fault_clear) begin
			next_s.fault_clear = 1'b0;
			next_s.err = 1'b0;
			next_s.out = 1'b0;
			next_s.por = 1'b0;
			next_s.low_sup = 1'b0;
			next_s.ref_f = 1'b0;
			next_s.tsd = 1'b0;
			next_s.crc = 1'b0;
			next_s.open_f = '0;
			next_s.short_f = '0;
			next_s.ss_f = '0;
		end

		if (wr_fire) begin
			if (s.awaddr == ADDR_CTRL) begin
				next_s.fault_clear = wr_word[CTRL_CLR];
				next_s.auto_scan = wr_word[CTRL_SCAN];
				if (wr_word[CTRL_INIT] && s.pwr == PWR_INIT) begin
					next_s.pwr = PWR_NORMAL;
				end
			end else if (s.awaddr == ADDR_MASK) begin
				next_s.mask = wr_word[MK_W-1:0];
			end else if (s.awaddr == ADDR_DIAG) begin
				next_s.diag_en = wr_word[NCH-1:0];
			end else if (s.awaddr == ADDR_TH) begin
				// Clamped so the threshold never leaves the usable span
				if (wr_word[7:0] < TH_MIN) begin
					next_s.low_th = TH_MIN;
				end else if (wr_word[7:0] > TH_MAX) begin
					next_s.low_th = TH_MAX;
				end else begin
					next_s.low_th = wr_word[7:0];
				end
			end else if (s.awaddr == ADDR_SEL) begin
				next_s.sel = wr_word[SEL_W-1:0];
				next_s.done = 1'b0;
				next_s.manual_pend = 1'b1;
				next_s.period_seen = 1'b0;
			end
		end

		// ****************************************************************
		// Converter sequencer
		// ****************************************************************
		case (s.adc)
			ADC_IDLE: begin
				if (s.manual_pend) begin
					next_s.manual_pend = 1'b0;
					if ((s.sel >= CH_RSV_LO && s.sel <= CH_RSV_HI) ||
						s.sel > CH_OUT11) begin
						next_s.result = 8'h0;
						next_s.done = 1'b1;
					end else if (s.sel == CH_MAX && s.auto_scan) begin
						next_s.scan_idx = 4'h0;
						next_s.adc_mux = CH_OUT0;
						next_s.adc_start = 1'b1;
						next_s.adc = ADC_SCAN;
					end else begin
						next_s.adc_mux = s.sel;
						next_s.adc_start = 1'b1;
						next_s.adc = ADC_MAN;
					end
				end else begin
					next_s.adc_mux = CH_SUPPLY;
					next_s.adc_start = 1'b1;
					next_s.adc = ADC_SUP;
				end
			end
			ADC_SUP: begin
				if (adc_done) begin
					next_s.supply = adc_data;
					next_s.supply_ok = (adc_data >= s.low_th);
					if (adc_data < s.low_th) begin
						next_s.low_sup = 1'b1;
						lsup_evt = s.supply_ok;
					end
					next_s.adc = ADC_IDLE;
				end
			end
			ADC_MAN: begin
				if (adc_done) begin
					// A newer select discards this result
					if (!s.manual_pend) begin
						next_s.result = adc_data;
						next_s.done = 1'b1;
					end
					next_s.adc = ADC_IDLE;
				end
			end
			ADC_SCAN: begin
				if (pwm_period_end) begin
					next_s.period_seen = 1'b1;
				end
				if (adc_done) begin
					mx = (s.scan_idx == 4'h0 || adc_data > s.max_v) ?
						adc_data : s.max_v;
					next_s.max_v = mx;
					if (s.manual_pend) begin
						next_s.adc = ADC_IDLE;
					end else if (s.scan_idx == 4'(NCH - 1)) begin
						if (s.period_seen) begin
							next_s.result = mx;
							next_s.done = 1'b1;
							next_s.adc = ADC_IDLE;
						end else begin
							next_s.scan_idx = 4'h0;
							next_s.adc_mux = CH_OUT0;
							next_s.adc_start = 1'b1;
						end
					end else begin
						next_s.scan_idx = s.scan_idx + 4'h1;
						next_s.adc_mux = 5'(CH_OUT0 + {1'b0, next_s.scan_idx});
						next_s.adc_start = 1'b1;
					end
				end
			end
			default: begin
				next_s.adc = ADC_IDLE;
			end
		endcase

		// ****************************************************************
		// Power state and fault latching
		// ****************************************************************
		trig = 1'b0;
		if (uv) begin
			next_s.pwr = PWR_POR;
			next_s.done = 1'b0;
			next_s.err = 1'b0;
			next_s.out = 1'b0;
			next_s.por = 1'b0;
			next_s.low_sup = 1'b0;
			next_s.ref_f = 1'b0;
			next_s.tsd = 1'b0;
			next_s.crc = 1'b0;
			next_s.open_f = '0;
			next_s.short_f = '0;
			next_s.ss_f = '0;
			next_s.pulse_cnt = 12'h0;
		end else if (s.pwr == PWR_POR) begin
			next_s.pwr = PWR_INIT;
			next_s.por = 1'b1;
			next_s.err = 1'b1;
		end else begin
			next_s.open_f = next_s.open_f | open_set;
			next_s.short_f = next_s.short_f | short_set;
			next_s.ss_f = next_s.ss_f | ss_set;
			next_s.ref_f = next_s.ref_f | ref_set;
			next_s.tsd = next_s.tsd | s.sy2[SY_TSD];
			next_s.crc = next_s.crc | crc_err;
			if (rep_open || rep_short) begin
				next_s.out = 1'b1;
			end
			if (rep_open || rep_short || const_low ||
				(ref_set && !s.mask[MK_REF]) ||
				(s.sy2[SY_TSD] && !s.mask[MK_TSD]) ||
				(crc_err && !s.mask[MK_CRC])) begin
				next_s.err = 1'b1;
			end
			trig = lsup_evt || (crc_err && !s.mask[MK_CRC]) ||
				((|(open_set & ~s.open_f)) && !s.mask[MK_OPEN]) ||
				((|((short_set & ~s.short_f) | (ss_set & ~s.ss_f))) &&
				!s.mask[MK_SHORT]);
			if (trig) begin
				next_s.pulse_cnt = PULSE_CYC;
			end else if (s.pulse_cnt != 12'h0) begin
				next_s.pulse_cnt = s.pulse_cnt - 12'h1;
			end
		end
		next_s.err_n = !((next_s.pulse_cnt != 12'h0) || const_low);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.diag_en <= DIAG_EN_RST;
			s.low_th <= TH_MIN;
			s.err_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign adc_start     = s.adc_start;
	assign adc_mux       = s.adc_mux;
	assign err_n         = s.err_n;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_clear_self: assert property (s.fault_clear |=> !s.fault_clear)
		else $error("fault clear bit did not return to zero");
	a_sel_clear: assert property (wr_fire && s.awaddr == ADDR_SEL &&
		s.adc == ADC_IDLE |=> !s.done && s.manual_pend)
		else $error("select write did not clear done");
	a_rsv_answer: assert property (s.adc == ADC_IDLE && s.manual_pend &&
		s.sel > CH_OUT11 && !wr_fire && !uv |=> s.done && s.result == 8'h0)
		else $error("reserved select not answered with zero");
	a_out_route: assert property (s.adc == ADC_IDLE && s.manual_pend &&
		s.sel >= CH_OUT0 && s.sel <= CH_OUT11 |=>
		s.adc_start && s.adc_mux == $past(s.sel))
		else $error("output channel not routed");
	a_max_valid: assert property (s.adc == ADC_SCAN ##1
		(s.done && !$past(s.done)) |-> $past(s.period_seen))
		else $error("maximum stored before a PWM period");
	a_pulse_low: assert property (s.pulse_cnt == PULSE_CYC |->
		!err_n [*8])
		else $error("error pin pulse too short");
	a_ref_hold: assert property (active && ref_set && !s.mask[MK_REF] &&
		!uv ##1 !uv |-> !err_n)
		else $error("reference fault did not hold pin low");
	a_uv_por: assert property (uv |=> s.pwr == PWR_POR)
		else $error("undervoltage did not force reset state");
	a_por_exit: assert property (s.pwr == PWR_POR && !uv |=>
		s.pwr == PWR_INIT && s.por && s.err)
		else $error("recovery did not set power-on flags");
	a_low_gate: assert property (!s.supply_ok && !s.fault_clear && !uv
		|=> s.open_f == $past(s.open_f) || $past(s.pwr) == PWR_POR)
		else $error("open fault latched under low supply");
	a_rd_clear: assert property (s.rvalid && s_axi_rready && s.rd_result &&
		s.adc == ADC_IDLE && !s.manual_pend |=> !s.done)
		else $error("result read did not clear done");

	c_scan_done: cover property (s.adc == ADC_SCAN ##1 s.done);
	c_low_pulse: cover property (lsup_evt ##1 !err_n);
	c_ref_fault: cover property (s.ref_f && !err_n);
	c_por_exit: cover property (s.pwr == PWR_POR ##1 s.pwr == PWR_INIT);

endmodule : ldd_diag
`default_nettype wire

// *** verification/ldd_mcu.sv ***
// Controller model: AXI4-Lite master making one register access at a time
`timescale 1ns/1ps
`default_nettype none
module ldd_mcu (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Each item moves at the rising edge where its valid and ready are high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			d = rdata;
			r = rresp;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : rd
endmodule : ldd_mcu
`default_nettype wire

// *** verification/ldd_diag_tb.sv ***
// Self-checking bench of the diagnostics block with a converter model
`timescale 1ns/1ps
`default_nettype none
module ldd_diag_tb;
	import ldd_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, adc_done = 1'b0, pwm = 1'b0;
	logic        tsd = 1'b0, crc = 1'b0, reg_uv = 1'b0;
	logic [7:0]  awaddr, araddr, sup, adc_data = '0;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [11:0] open_det = '0, short_det = '0;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
	logic        arready, rvalid, rready, adc_start, err_n;
	logic        ref_v = 1'b0, ref_i = 1'b0, sup_uv = 1'b0;
	logic [4:0]  adc_mux;
	int          failures = 0, comparisons = 0, cnt = 0, tick = 0;
	localparam logic [4:0] CODES [6] = '{5'h02, 5'h12, 5'h1b, 5'h07, 5'h1d,
		5'h05};
	always #12.5 aclk = ~aclk;
	ldd_mcu i_mcu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	ldd_diag i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .supply_uv(sup_uv), .regulator_uv(reg_uv),
		.ref_current_low(ref_i), .ref_voltage_low(ref_v), .tsd_det(tsd),
		.open_det(open_det), .short_det(short_det), .ss_det(12'h0),
		.crc_err(crc), .pwm_period_end(pwm), .adc_done(adc_done),
		.adc_data(adc_data), .adc_start(adc_start), .adc_mux(adc_mux),
		.err_n(err_n));
	// Converter answers four cycles after each start; PWM period is 40 cycles
	always @(posedge aclk) begin
		adc_done <= 1'b0;
		tick <= tick + 1;
		pwm <= (tick % 40 == 39);
		if (adc_start) cnt <= 4;
		else if (cnt > 0) cnt <= cnt - 1;
		if (cnt == 1) begin
			adc_done <= 1'b1;
			adc_data <= (adc_mux == CH_SUPPLY) ? sup : {3'h5, adc_mux};
		end
	end
	function automatic logic [31:0] expv(input logic [4:0] c);
		// Auto-scan maximum: the highest output code models the top voltage
		if (c == CH_MAX) return {24'h0, 3'h5, CH_OUT11};
		if ((c > 5'h05 && c < 5'h10) || c > 5'h1b) return 32'h0;
		return {24'h0, 3'h5, c};
	endfunction : expv
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, m,
		input string n);
		i_mcu.rd(a, v, r);
		chk(n, v & m, e);
	endtask : rdc
	task automatic clr;
		i_mcu.wr(ADDR_CTRL, 32'h1);
		chk("bresp", 32'(bresp), 32'(RESP_OKAY));
	endtask : clr
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (30000) @(posedge aclk);
		failures++;
		wrap_up;
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		v = 32'($urandom(32'h09200795));
		sup = 8'h80 + 8'($urandom % 112);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (30) @(posedge aclk);
		rdc(ADDR_STATUS, 32'h10a, 32'h30a, "por");
		rdc(ADDR_MASK, 32'h0, 32'h1f, "mask");
		rdc(ADDR_DIAG, 32'hfff, 32'hfff, "diag");
		rdc(ADDR_TH, 32'h3d, 32'hff, "thr");
		i_mcu.rd(8'h40, v, r);
		chk("unmapped", 32'(r), 32'(RESP_SLVERR));
		i_mcu.wr(8'h40, 32'h0);
		chk("wr unmapped", 32'(bresp), 32'(RESP_SLVERR));
		rdc(ADDR_SUPPLY, 32'(sup), 32'hff, "supply");
		clr;
		rdc(ADDR_STATUS, 32'h0, 32'hfe, "clear");
		rdc(ADDR_CTRL, 32'h0, 32'h1, "clear bit");
		// Auto-scan on, so that the maximum select scans all outputs
		i_mcu.wr(ADDR_CTRL, 32'h2);
		foreach (CODES[k]) begin
			i_mcu.wr(ADDR_SEL, 32'(CODES[k]));
			v = '0;
			for (int i = 0; i < 80 && v[0] !== 1'b1; i++)
				i_mcu.rd(ADDR_STATUS, v, r);
			chk("done", 32'(v[0]), 32'h1);
			rdc(ADDR_RESULT, expv(CODES[k]), 32'hff, "result");
			rdc(ADDR_STATUS, 32'h0, 32'h1, "done read");
		end
		i_mcu.wr(ADDR_MASK, 32'h2);
		open_det <= 12'h008;
		repeat (10) @(posedge aclk);
		chk("pin masked", 32'(err_n), 32'h1);
		rdc(ADDR_OPEN, 32'h8, 32'hfff, "open kept");
		rdc(ADDR_STATUS, 32'h0, 32'h6, "open masked");
		open_det <= 12'h0;
		i_mcu.wr(ADDR_MASK, 32'h0);
		clr;
		open_det <= 12'h008;
		repeat (10) @(posedge aclk);
		chk("pin pulse", 32'(err_n), 32'h0);
		rdc(ADDR_STATUS, 32'h6, 32'h6, "open flag");
		i_mcu.wr(ADDR_DIAG, 32'hff7);
		clr;
		short_det <= 12'h009;
		repeat (10) @(posedge aclk);
		rdc(ADDR_SHORT, 32'h1, 32'hfff, "diag off");
		{open_det, short_det} <= '0;
		for (int k = 0; k < 2; k++) begin
			{ref_v, ref_i} <= 2'(k + 1);
			repeat (2100) @(posedge aclk);
			chk("pin held", 32'(err_n), 32'h0);
			rdc(ADDR_STATUS, 32'h22, 32'h22, "ref");
			{ref_v, ref_i} <= 2'h0;
			clr;
		end
		i_mcu.wr(ADDR_MASK, 32'h18);
		{tsd, crc} <= 2'h3;
		@(posedge aclk);
		crc <= 1'b0;
		repeat (10) @(posedge aclk);
		chk("tsd crc pin", 32'(err_n), 32'h1);
		rdc(ADDR_STATUS, 32'hc0, 32'hc2, "tsd crc masked");
		tsd <= 1'b0;
		i_mcu.wr(ADDR_MASK, 32'h0);
		clr;
		i_mcu.wr(ADDR_TH, 32'hff);
		rdc(ADDR_TH, 32'hf8, 32'hff, "thr clamp");
		repeat (20) @(posedge aclk);
		rdc(ADDR_STATUS, 32'h10, 32'h10, "low supply");
		chk("low pin", 32'(err_n), 32'h0);
		open_det <= 12'h001;
		repeat (10) @(posedge aclk);
		rdc(ADDR_OPEN, 32'h0, 32'hfff, "open gated");
		i_mcu.wr(ADDR_CTRL, 32'h4);
		rdc(ADDR_STATUS, 32'h200, 32'h300, "normal");
		for (int k = 0; k < 2; k++) begin
			{reg_uv, sup_uv} <= 2'(k + 1);
			repeat (8) @(posedge aclk);
			{reg_uv, sup_uv} <= 2'h0;
			repeat (8) @(posedge aclk);
			rdc(ADDR_STATUS, 32'h10a, 32'h30e, "uv");
		end
		wrap_up;
	end
endmodule : ldd_diag_tb
`default_nettype wire
